// [core/ref_step_timer.sv]
// Purpose: Down counter that reports busy while a loaded wait is running.
// Assumes: Load takes priority over counting.
// Notes:   Busy is high from the cycle after load for exactly the loaded count.
`timescale 1ns/1ps
`default_nettype none
module ref_step_timer #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = count;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign busy = (cnt_reg != '0);
endmodule
`default_nettype wire

// [core/ref_train_ctrl.sv]
// Purpose: Holds the reference training control register and derives the reference.
// Assumes: The controller keeps its own spacing; this block only flags breaches.
// Notes:   Reference output is in hundredths of a percent of the output supply.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Level code comes from bits 5 to 0 of the control write and is applied.
// - Bit 7 enables training; bit 6 selects the range.
// - Range bit clear gives the 60 percent range; set gives 45 percent.
// - Code zero is range bottom; each code adds one typical step.
// - Range and level update on every write whatever the enable bit.
module ref_train_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_data,
    output logic             training_on,
    output logic             range_sel,
    output logic [5:0]       level_code,
    output logic [13:0]      data_input_reference,
    output logic             cmd_busy,
    output logic             timing_violation,
    output logic             reserved_code
);
    ref_train_pkg::ctrl_s  ctrl_reg;
    ref_train_pkg::ctrl_s  ctrl_next;
    ref_train_pkg::ctrl_s  wr;
    logic [13:0]           ref_reg;
    logic [13:0]           ref_next;
    logic                  viol_reg;
    logic                  viol_next;
    logic                  rsv_reg;
    logic                  rsv_next;
    logic                  busy_reg;
    logic                  busy_next;
    logic                  load;
    logic [3:0]            load_cnt;
    logic                  timer_busy;
    logic [5:0]            diff;

    assign wr = ref_train_pkg::ctrl_s'(cmd_data);

    // =========================================================================
    // Control register and reference
    // =========================================================================
    always_comb begin
        ctrl_next = ctrl_reg;
        if (cmd_valid) begin
            ctrl_next = wr;
        end
        ref_next = (ctrl_next.range ? ref_train_pkg::RANGE_LOWER_BASE
                                    : ref_train_pkg::RANGE_UPPER_BASE)
                 + 14'(ctrl_next.level) * ref_train_pkg::STEP_TYP;
    end

    // =========================================================================
    // Wait selection and breach flag
    // =========================================================================
    always_comb begin
        diff = (wr.level > ctrl_reg.level) ? wr.level - ctrl_reg.level
                                           : ctrl_reg.level - wr.level;
        // The write cycle is the first cycle of its own wait, so the timer gets one less.
        // Loading the full count would flag a write that arrives exactly on time.
        load     = 1'b0;
        load_cnt = '0;
        if (cmd_valid) begin
            if (wr.enable && !ctrl_reg.enable) begin
                load = 1'b1;
                load_cnt = 4'(ref_train_pkg::ENTRY_DELAY_CYC - 1);
            end else if (!wr.enable && ctrl_reg.enable) begin
                load = 1'b1;
                load_cnt = 4'(ref_train_pkg::EXIT_DELAY_CYC - 1);
            end else if (wr.range != ctrl_reg.range || diff > 6'h01) begin
                load = 1'b1;
                load_cnt = 4'(ref_train_pkg::STEP_LONG_CYC - 1);
            end else if (diff == 6'h01) begin
                load = 1'b1;
                load_cnt = 4'(ref_train_pkg::STEP_SHORT_CYC - 1);
            end
        end
        // Breaches are sticky so a controller model can read them after a run.
        viol_next = viol_reg
                  | (cmd_valid & timer_busy)
                  | (cmd_valid & ~wr.enable & ctrl_reg.enable
                     & (wr.level != ctrl_reg.level));
        rsv_next  = cmd_valid ? (wr.level > ref_train_pkg::LEVEL_MAX) : rsv_reg;
        busy_next = load | timer_busy;
    end

    ref_step_timer #(
        .W       (ref_train_pkg::TIMER_W)
    ) u_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .load    (load),
        .count   (load_cnt),
        .busy    (timer_busy)
    );

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_reg <= ref_train_pkg::CTRL_RESET;
            ref_reg  <= ref_train_pkg::RANGE_UPPER_BASE;
            viol_reg <= 1'b0;
            rsv_reg  <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ref_reg  <= ref_next;
            viol_reg <= viol_next;
            rsv_reg  <= rsv_next;
            busy_reg <= busy_next;
        end
    end

    assign training_on          = ctrl_reg.enable;
    assign range_sel            = ctrl_reg.range;
    assign level_code           = ctrl_reg.level;
    assign data_input_reference = ref_reg;
    assign cmd_busy             = busy_reg;
    assign timing_violation     = viol_reg;
    assign reserved_code        = rsv_reg;

    // =========================================================================
    // Checks
    // =========================================================================
    property p_apply;
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid |=> (level_code == $past(cmd_data[5:0])) && (range_sel == $past(cmd_data[6]));
    endproperty
    a_apply: assert property (p_apply) else $error("Level or range not applied.");

    property p_enable;
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid |=> training_on == $past(cmd_data[7]);
    endproperty
    a_enable: assert property (p_enable) else $error("Enable bit not applied.");

    property p_hold;
        @(posedge clk_sys) disable iff (!resetn)
        !cmd_valid |=> $stable(level_code) && $stable(range_sel) && $stable(training_on);
    endproperty
    a_hold: assert property (p_hold) else $error("Control changed without a write.");

    property p_ref;
        @(posedge clk_sys) disable iff (!resetn)
        data_input_reference == (range_sel ? 14'h1194 : 14'h1770) + 14'(level_code) * 14'h0041;
    endproperty
    a_ref: assert property (p_ref) else $error("Reference does not match code.");

    property p_short;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && cmd_data[7] == training_on && cmd_data[6] == range_sel
         && (cmd_data[5:0] == level_code + 6'h01)) |=> cmd_busy;
    endproperty
    a_short: assert property (p_short) else $error("Short wait not started.");

    property p_long;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && cmd_data[7] == training_on && cmd_data[6] != range_sel)
        |=> cmd_busy [*2];
    endproperty
    a_long: assert property (p_long) else $error("Long wait too short.");

    property p_entry;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && cmd_data[7] && !training_on)
        |=> cmd_busy [*2] ##1 (!cmd_busy || $past(cmd_valid));
    endproperty
    a_entry: assert property (p_entry) else $error("Entry wait wrong.");

    property p_busy_viol;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && timer_busy) |=> timing_violation;
    endproperty
    a_busy_viol: assert property (p_busy_viol) else $error("Breach not flagged.");

    property p_rsv;
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid |=> reserved_code == ($past(cmd_data[5:0]) > 6'h32);
    endproperty
    a_rsv: assert property (p_rsv) else $error("Reserved code flag wrong.");

    property p_exit;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && !cmd_data[7] && training_on)
        |=> cmd_busy [*2] ##1 (!cmd_busy || $past(cmd_valid));
    endproperty
    a_exit: assert property (p_exit) else $error("Exit wait wrong.");

    property p_short_end;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && cmd_data[7] == training_on && cmd_data[6] == range_sel
         && level_code < 6'h3F && cmd_data[5:0] < 6'h3F
         && (cmd_data[5:0] == level_code + 6'h01 || level_code == cmd_data[5:0] + 6'h01))
        |=> cmd_busy ##1 (!cmd_busy || $past(cmd_valid));
    endproperty
    a_short_end: assert property (p_short_end) else $error("Short wait wrong length.");

    property p_long_end;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && cmd_data[7] == training_on && cmd_data[6] != range_sel)
        |=> cmd_busy [*2] ##1 (!cmd_busy || $past(cmd_valid));
    endproperty
    a_long_end: assert property (p_long_end) else $error("Long wait too long.");

    property p_exit_level;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && !cmd_data[7] && training_on && cmd_data[5:0] != level_code)
        |=> timing_violation;
    endproperty
    a_exit_level: assert property (p_exit_level) else $error("Exit level change missed.");

    property p_sticky;
        @(posedge clk_sys) disable iff (!resetn)
        timing_violation |=> timing_violation;
    endproperty
    a_sticky: assert property (p_sticky) else $error("Breach flag cleared.");

    property p_quiet;
        @(posedge clk_sys) disable iff (!resetn)
        (cmd_valid && !cmd_busy && cmd_data == {training_on, range_sel, level_code})
        |=> !cmd_busy;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Wait started without a change.");
endmodule
`default_nettype wire

// [core/ref_train_pkg.sv]
// Purpose: Shared constants and carriers for the data input reference training block.
// Assumes: One 10 MHz system clock; mode register writes arrive as single-cycle strobes.
// Notes:   Times are kept in ns and converted to cycles here, rounding least times up.
package ref_train_pkg;

    // =========================================================================
    // Clock and timing
    // =========================================================================
    localparam int CLK_PERIOD_NS          = 100;
    localparam int STEP_SHORT_NS          = 60;
    localparam int STEP_LONG_NS           = 150;
    localparam int ENTRY_DELAY_NS         = 150;
    localparam int EXIT_DELAY_NS          = 150;
    localparam int STEP_SHORT_CYC  = (STEP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_LONG_CYC   = (STEP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENTRY_DELAY_CYC = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_DELAY_CYC  = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W                = 4;

    // =========================================================================
    // Register layout
    // =========================================================================
    localparam int REG_W                  = 8;
    localparam int ENABLE_BIT             = 7;
    localparam int RANGE_BIT              = 6;
    localparam int LEVEL_W                = 6;
    localparam logic [5:0] LEVEL_MAX      = 6'h32;
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // Reference in hundredths of a percent of the output supply.
    localparam logic [13:0] RANGE_UPPER_BASE = 14'h1770;
    localparam logic [13:0] RANGE_LOWER_BASE = 14'h1194;
    localparam logic [13:0] STEP_TYP         = 14'h0041;

    typedef struct packed {
        logic       enable;
        logic       range;
        logic [5:0] level;
    } ctrl_s;

    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_EXIT} phase_e;

endpackage

// [verification/ref_ctrl_partner.sv]
// Purpose: Controller-side model that issues reference control writes.
// Assumes: Writes launch at the falling edge; released data lines are inverted.
// Notes:   Prompt mode skips the spacing so a scenario can break it on purpose.
`timescale 1ns/1ps
`default_nettype none
module ref_ctrl_partner (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data
);
    logic [7:0] last;

    initial begin
        cmd_valid = 1'b0;
        cmd_data  = 8'hFF;
        last      = 8'h00;
    end

    always @(negedge clk_sys) begin
        if (!resetn) begin
            last = 8'h00;
        end
    end

    // =========================================================================
    // Spacing
    // =========================================================================
    // An enable change outranks the step size of the same write.
    function automatic int gap(input logic [7:0] a, input logic [7:0] b);
        int d;
        d = int'(a[5:0]) - int'(b[5:0]);
        if (a[7] != b[7]) return b[7] ? ref_train_pkg::ENTRY_DELAY_CYC
            : ref_train_pkg::EXIT_DELAY_CYC;
        if (a[6] != b[6] || d > 1 || d < -1) return ref_train_pkg::STEP_LONG_CYC;
        return (d != 0) ? ref_train_pkg::STEP_SHORT_CYC : 0;
    endfunction

    task automatic send(input logic [7:0] d, input logic keep);
        int n;
        n = gap(last, d);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_data  = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_data  = ~d;
        last      = d;
        // The release edge and the next call's own edge already give two cycles.
        if (keep && n > 2) begin
            repeat (n - 2) @(negedge clk_sys);
        end
    endtask

    // Two writes on consecutive edges; the strobe stays up between them.
    task automatic send_pair(input logic [7:0] d0, input logic [7:0] d1);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_data  = d0;
        @(negedge clk_sys);
        cmd_data  = d1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_data  = ~d1;
        last      = d1;
    endtask
endmodule
`default_nettype wire

// [verification/ref_train_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the reference training control block.
// Assumes: The partner model issues every write; the bench drives reset.
// Notes:   The violation flag is sticky, so breaking scenarios run last.
`timescale 1ns/1ps
`default_nettype none
module ref_train_ctrl_tb_top;
    localparam int short_wait = ref_train_pkg::STEP_SHORT_CYC;
    localparam int long_wait  = ref_train_pkg::STEP_LONG_CYC;
    localparam int entry_wait = ref_train_pkg::ENTRY_DELAY_CYC;
    localparam int exit_wait  = ref_train_pkg::EXIT_DELAY_CYC;
    logic        clk_sys = 1'b0;
    logic        resetn  = 1'b0;
    logic        cmd_valid;
    logic [7:0]  cmd_data;
    logic        training_on;
    logic        range_sel;
    logic [5:0]  level_code;
    logic [13:0] data_input_reference;
    logic        cmd_busy;
    logic        timing_violation;
    logic        reserved_code;
    int          fail_count = 0;
    int          checked    = 0;

    always #50 clk_sys = ~clk_sys;

    ref_ctrl_partner ref_ctrl_partner_inst (.clk_sys(clk_sys), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data));
    ref_train_ctrl ref_train_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .training_on(training_on),
        .range_sel(range_sel), .level_code(level_code),
        .data_input_reference(data_input_reference), .cmd_busy(cmd_busy),
        .timing_violation(timing_violation), .reserved_code(reserved_code));

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [13:0] exp_ref(input logic [7:0] d);
        return (d[6] ? ref_train_pkg::RANGE_LOWER_BASE : ref_train_pkg::RANGE_UPPER_BASE)
            + ref_train_pkg::STEP_TYP * d[5:0];
    endfunction

    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        chk("reset state", 14'h0000, {3'h0, training_on, range_sel, level_code, cmd_busy,
            timing_violation, reserved_code});
        chk("reset reference", exp_ref(8'h00), data_input_reference);
    endtask

    // Busy is counted over six cycles, longer than any wait, so spacing always holds.
    task automatic wr(input logic [7:0] d, input int waits, input logic viol);
        int seen;
        ref_ctrl_partner_inst.send(d, 1'b0);
        seen = int'(cmd_busy === 1'b1);
        repeat (5) begin
            @(negedge clk_sys);
            seen += int'(cmd_busy === 1'b1);
        end
        chk("busy cycles", 14'(waits), 14'(seen));
        chk("control", {6'h00, d}, {6'h00, training_on, range_sel, level_code});
        chk("reserved_code", 14'(d[5:0] > ref_train_pkg::LEVEL_MAX), 14'(reserved_code));
        if (d[5:0] <= ref_train_pkg::LEVEL_MAX) chk("reference", exp_ref(d), data_input_reference);
        chk("timing_violation", 14'(viol), 14'(timing_violation));
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =========================================================================
    // Tests
    // =========================================================================
    initial begin
        do_reset();
        ref_ctrl_partner_inst.send(8'h80, 1'b1);
        ref_ctrl_partner_inst.send(8'h81, 1'b1);
        ref_ctrl_partner_inst.send(8'hB2, 1'b1);
        ref_ctrl_partner_inst.send(8'h32, 1'b1);
        repeat (3) @(negedge clk_sys);
        chk("timing_violation", 14'h0000, 14'(timing_violation));
        $display("test minimum spacing done");
        do_reset();
        wr(8'h80, entry_wait, 1'b0);
        wr(8'h81, short_wait, 1'b0);
        wr(8'h80, short_wait, 1'b0);
        wr(8'hB2, long_wait, 1'b0);
        wr(8'hF2, long_wait, 1'b0);
        wr(8'hF2, 0, 1'b0);
        wr(8'hF1, short_wait, 1'b0);
        wr(8'h71, exit_wait, 1'b0);
        wr(8'h45, long_wait, 1'b0);
        wr(8'h73, long_wait, 1'b0);
        $display("test legal sequence done");
        ref_ctrl_partner_inst.send_pair(8'hF3, 8'hF4);
        repeat (3) @(negedge clk_sys);
        chk("timing_violation", 14'h0001, 14'(timing_violation));
        do_reset();
        wr(8'h80, entry_wait, 1'b0);
        wr(8'h05, exit_wait, 1'b1);
        $display("test spacing and exit faults done");
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
